//--- inc/mic_pkg.sv
/*
 Constants for the processor interrupt controller: register addresses,
 bit positions, source indices in polling order and vector addresses.
 Assumes an 8-bit special register port driven by the processor core.
*/
`default_nettype none
package mic_pkg;
    localparam int NSRC = 11;
    localparam int LVLS = 4;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Register addresses
    localparam logic [7:0] A_TIMER_CTRL = 8'h88;
    localparam logic [7:0] A_EN_THIRD   = 8'h9A;
    localparam logic [7:0] A_EN_FIRST   = 8'hA8;
    localparam logic [7:0] A_PRIO_LOW   = 8'hA9;
    localparam logic [7:0] A_EN_SECOND  = 8'hB8;
    localparam logic [7:0] A_PRIO_HIGH  = 8'hB9;
    localparam logic [7:0] A_REQ_FLAGS  = 8'hC0;
    localparam logic [7:0] A_POL_CTRL   = 8'hC8;
    localparam logic [7:0] A_SUB_FLAG_A = 8'hE8;
    localparam logic [7:0] A_SUB_FLAG_B = 8'hF8;
    // Implemented bits per register
    localparam logic [7:0] M_EN_FIRST  = 8'h9F;
    localparam logic [7:0] M_EN_SECOND = 8'h3E;
    localparam logic [7:0] M_EN_THIRD  = 8'h01;
    localparam logic [7:0] M_POL       = 8'h60;
    localparam logic [7:0] M_SUB_A     = 8'hF7;
    localparam logic [7:0] M_SUB_B     = 8'hE0;
    localparam logic [7:0] M_PRIO      = 8'h3F;
    // Timer control bits
    localparam int B_T1_FLAG = 7;
    localparam int B_T1_RUN  = 6;
    localparam int B_T0_FLAG = 5;
    localparam int B_T0_RUN  = 4;
    localparam int B_X1_FLAG = 3;
    localparam int B_X1_TYPE = 2;
    localparam int B_X0_FLAG = 1;
    localparam int B_X0_TYPE = 0;
    // First enable bits; B_EN_S1 is bit 0 of the third enable
    localparam int B_GLOBAL = 7;
    localparam int B_EN_S0  = 4;
    localparam int B_EN_T1  = 3;
    localparam int B_EN_X1  = 2;
    localparam int B_EN_T0  = 1;
    localparam int B_EN_X0  = 0;
    localparam int B_EN_S1  = 0;
    // External 2..6 bits in second enable and request flags
    localparam int B_X2 = 1;
    localparam int B_X3 = 2;
    localparam int B_X4 = 3;
    localparam int B_X5 = 4;
    localparam int B_X6 = 5;
    // Polarity bits
    localparam int B_X3_POL = 6;
    localparam int B_X2_POL = 5;
    // Sub-flag bits
    localparam int B_XFER  = 0;
    localparam int B_SEC   = 1;
    localparam int B_MIN   = 2;
    localparam int B_TEMP  = 4;
    localparam int B_YPULS = 5;
    localparam int B_XPULS = 6;
    localparam int B_EEDON = 7;
    localparam int B_VPULS = 5;
    localparam int B_WPULS = 6;
    localparam int B_SPI   = 7;
    // Sub-flag groups per core line
    localparam logic [7:0] G2_A = 8'h60;
    localparam logic [7:0] G2_B = 8'h60;
    localparam logic [7:0] G5_A = 8'h80;
    localparam logic [7:0] G5_B = 8'h80;
    localparam logic [7:0] G6_A = 8'h17;
    localparam logic [7:0] G6_B = 8'h00;
    // Sources in polling order; group is index / 2
    localparam logic [3:0] S_X0 = 4'h0;
    localparam logic [3:0] S_S1 = 4'h1;
    localparam logic [3:0] S_T0 = 4'h2;
    localparam logic [3:0] S_X2 = 4'h3;
    localparam logic [3:0] S_X1 = 4'h4;
    localparam logic [3:0] S_X3 = 4'h5;
    localparam logic [3:0] S_T1 = 4'h6;
    localparam logic [3:0] S_X4 = 4'h7;
    localparam logic [3:0] S_S0 = 4'h8;
    localparam logic [3:0] S_X5 = 4'h9;
    localparam logic [3:0] S_X6 = 4'hA;
    localparam logic [15:0] VEC_TABLE [NSRC] = '{
        16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
        16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h006B};
endpackage
`default_nettype wire

//--- rtl/mic_top.sv
/*
 Interrupt controller of the 8-bit processor: flags, enables, trigger
 selection, priority polling, vectoring and nesting.
 Assumes the core gives machine-cycle and instruction-end pulses, flags
 RETI, and acknowledges the vector call; peripherals share clk_in.
*/
// Operation
// - Eleven sources in six groups, each group assignable to one of four priority levels.
// - Global enable at zero blocks every interrupt.
// - Only a strictly higher level preempts a running service.
// - RETI ends the active service level.
// - Flags set on their condition regardless of enables.
// - Flags sampled once per machine cycle, then the samples polled.
// - Pending enabled request forces a call to its vector next instruction.
// - No acknowledge during RETI or writes to enable or priority registers.
// - First enable: global bit 7, serial 0, timer 1, ext 1, timer 0, ext 0.
// - Second enable: external 6 down to 2 at bits 5 to 1.
// - Third enable bit 0 enables serial channel 1.
// - Timer control holds timer and external 0/1 flags.
// - Type bits: 0 low level, 1 falling edge for external 0/1.
// - Polarity bits for external 3 and 2: 0 falling, 1 rising.
// - Request register holds external 6 to 2 flags at bits 5 to 1.
// - Timer flags cleared on entry with active-high acknowledge pulses.
// - External 0 to 6 flags clear on vectoring.
// - External 5 and 6 fire on rising edges of their sub-flag lines.
// - External 2 from pulse events, external 3 from engine busy.
// - External 4 fires when the supply status field changes.
// - External 5 and 6 combine busy falls with serial, clock and temperature events.
// - Group level is one bit from each priority register.
// - Equal levels resolved by fixed polling order.
// - Sub-flags clear only on a written zero.
// - Each source calls its own fixed vector address.
`timescale 1ns/10ps
`default_nettype none
module mic_top (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_b_in,
    // Register port
    input  wire logic [7:0]         sfr_addr_in,
    input  wire logic               sfr_wr_in,
    input  wire logic               sfr_rd_in,
    input  wire logic [7:0]         sfr_wdata_in,
    output logic      [7:0]         sfr_rdata_out,
    // Core handshake
    input  wire logic               machine_cycle_in,
    input  wire logic               instr_end_in,
    input  wire logic               reti_in,
    input  wire logic               lcall_ack_in,
    output logic                    lcall_req_out,
    output logic      [15:0]        lcall_vector_out,
    output logic      [3:0]         irq_source_out,
    output logic                    timer_zero_service_ack_out,
    output logic                    timer_one_service_ack_out,
    output logic      [1:0]         timer_run_out,
    // Internal sources
    input  wire logic               timer_zero_overflow_in,
    input  wire logic               timer_one_overflow_in,
    input  wire logic               serial_zero_request_in,
    input  wire logic               serial_one_request_in,
    // External pins
    input  wire logic               ext_zero_pin_in,
    input  wire logic               ext_one_pin_in,
    // Peripheral events
    input  wire logic               x_pulse_in,
    input  wire logic               y_pulse_in,
    input  wire logic               w_pulse_in,
    input  wire logic               v_pulse_in,
    input  wire logic               ce_busy_in,
    input  wire logic [2:0]         supply_status_field_in,
    input  wire logic               eeprom_busy_in,
    input  wire logic               serial_port_event_in,
    input  wire logic               transfer_busy_signal_in,
    input  wire logic               clock_second_tick_in,
    input  wire logic               clock_minute_tick_in,
    input  wire logic               temperature_event_in,
    input  wire logic [7:0]         sub_enable_a_in,
    input  wire logic [7:0]         sub_enable_b_in
);
    import mic_pkg::*;

    typedef struct packed {
        logic [7:0]  tmr_ctl;
        logic [7:0]  en_a;
        logic [7:0]  en_b;
        logic [7:0]  en_c;
        logic [7:0]  prio_lo;
        logic [7:0]  prio_hi;
        logic [7:0]  pol;
        logic [7:0]  xreq;
        logic [7:0]  sub_a;
        logic [7:0]  sub_b;
        logic [1:0]  pin_m;
        logic [1:0]  pin_s;
        logic [1:0]  pin_p;
        logic        int2_p;
        logic        busy_p;
        logic        int5_p;
        logic        int6_p;
        logic [2:0]  vst_p;
        logic        ee_p;
        logic        spi_p;
        logic        xfer_p;
        logic [10:0] smp;
        logic        blk;
        logic [3:0]  act;
        logic        req;
        logic [3:0]  src;
        logic [15:0] vec;
        logic        ack0;
        logic        ack1;
        logic [7:0]  rdata;
    } mic_state_t;

    mic_state_t s;
    mic_state_t n;

    function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] b);
        return en && (a == b);
    endfunction

    function automatic logic [1:0] lvl_of(input logic [7:0] lo, input logic [7:0] hi, input int i);
        return {hi[i / 2], lo[i / 2]};
    endfunction

    function automatic logic [2:0] top_act(input logic [3:0] a);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 0; k < LVLS; k++) begin
            if (a[k]) begin
                r = {1'b1, 2'(k)};
            end
        end
        return r;
    endfunction

    logic [1:0]  fall01;
    logic        line2;
    logic        line5;
    logic        line6;
    logic [10:0] pend;
    logic [10:0] ens;
    logic        found;
    logic [3:0]  best;
    logic [1:0]  best_lvl;
    logic [2:0]  cur;
    logic        blk_now;
    logic        vect;

    always_comb begin
        n = s;
        n.ack0 = 1'b0;
        n.ack1 = 1'b0;
        // Pin synchronisers
        n.pin_m = {ext_one_pin_in, ext_zero_pin_in};
        n.pin_s = s.pin_m;
        n.pin_p = s.pin_s;
        fall01 = s.pin_p & ~s.pin_s;
        // Core lines from sub-sources
        line2 = |(s.sub_a & sub_enable_a_in & G2_A) | |(s.sub_b & sub_enable_b_in & G2_B);
        line5 = |(s.sub_a & sub_enable_a_in & G5_A) | |(s.sub_b & sub_enable_b_in & G5_B);
        line6 = |(s.sub_a & sub_enable_a_in & G6_A) | |(s.sub_b & sub_enable_b_in & G6_B);
        n.int2_p = line2;
        n.int5_p = line5;
        n.int6_p = line6;
        n.busy_p = ce_busy_in;
        n.vst_p = supply_status_field_in;
        n.ee_p = eeprom_busy_in;
        n.xfer_p = transfer_busy_signal_in;
        n.spi_p = serial_port_event_in;

        // Software writes
        if (hit(sfr_wr_in, sfr_addr_in, A_TIMER_CTRL)) begin
            n.tmr_ctl = sfr_wdata_in;
        end
        if (hit(sfr_wr_in, sfr_addr_in, A_EN_FIRST)) begin
            n.en_a = sfr_wdata_in & M_EN_FIRST;
        end
        if (hit(sfr_wr_in, sfr_addr_in, A_EN_SECOND)) begin
            n.en_b = sfr_wdata_in & M_EN_SECOND;
        end
        if (hit(sfr_wr_in, sfr_addr_in, A_EN_THIRD)) begin
            n.en_c = sfr_wdata_in & M_EN_THIRD;
        end
        if (hit(sfr_wr_in, sfr_addr_in, A_PRIO_LOW)) begin
            n.prio_lo = sfr_wdata_in & M_PRIO;
        end
        if (hit(sfr_wr_in, sfr_addr_in, A_PRIO_HIGH)) begin
            n.prio_hi = sfr_wdata_in & M_PRIO;
        end
        if (hit(sfr_wr_in, sfr_addr_in, A_POL_CTRL)) begin
            n.pol = sfr_wdata_in & M_POL;
        end
        if (hit(sfr_wr_in, sfr_addr_in, A_REQ_FLAGS)) begin
            n.xreq = sfr_wdata_in & M_EN_SECOND;
        end
        if (hit(sfr_wr_in, sfr_addr_in, A_SUB_FLAG_A)) begin
            n.sub_a = s.sub_a & sfr_wdata_in;
        end
        if (hit(sfr_wr_in, sfr_addr_in, A_SUB_FLAG_B)) begin
            n.sub_b = s.sub_b & sfr_wdata_in;
        end

        // Vectoring: clear flags, enter level
        vect = lcall_ack_in && s.req;
        if (vect) begin
            n.req = 1'b0;
            n.act[lvl_of(s.prio_lo, s.prio_hi, int'(s.src))] = 1'b1;
            case (s.src)
                S_X0: n.tmr_ctl[B_X0_FLAG] = 1'b0;
                S_X1: n.tmr_ctl[B_X1_FLAG] = 1'b0;
                S_T0: begin
                    n.tmr_ctl[B_T0_FLAG] = 1'b0;
                    n.ack0 = 1'b1;
                end
                S_T1: begin
                    n.tmr_ctl[B_T1_FLAG] = 1'b0;
                    n.ack1 = 1'b1;
                end
                S_X2: n.xreq[B_X2] = 1'b0;
                S_X3: n.xreq[B_X3] = 1'b0;
                S_X4: n.xreq[B_X4] = 1'b0;
                S_X5: n.xreq[B_X5] = 1'b0;
                S_X6: n.xreq[B_X6] = 1'b0;
                default: ;
            endcase
        end

        // Hardware sets win over clears
        if (s.tmr_ctl[B_X0_TYPE] ? fall01[0] : ~s.pin_s[0]) begin
            n.tmr_ctl[B_X0_FLAG] = 1'b1;
        end
        if (s.tmr_ctl[B_X1_TYPE] ? fall01[1] : ~s.pin_s[1]) begin
            n.tmr_ctl[B_X1_FLAG] = 1'b1;
        end
        if (timer_zero_overflow_in) begin
            n.tmr_ctl[B_T0_FLAG] = 1'b1;
        end
        if (timer_one_overflow_in) begin
            n.tmr_ctl[B_T1_FLAG] = 1'b1;
        end
        // Sub-source flags
        if (x_pulse_in) begin
            n.sub_a[B_XPULS] = 1'b1;
        end
        if (y_pulse_in) begin
            n.sub_a[B_YPULS] = 1'b1;
        end
        if (w_pulse_in) begin
            n.sub_b[B_WPULS] = 1'b1;
        end
        if (v_pulse_in) begin
            n.sub_b[B_VPULS] = 1'b1;
        end
        if (~eeprom_busy_in & s.ee_p) begin
            n.sub_a[B_EEDON] = 1'b1;
        end
        if (serial_port_event_in & ~s.spi_p) begin
            n.sub_b[B_SPI] = 1'b1;
        end
        if (~transfer_busy_signal_in & s.xfer_p) begin
            n.sub_a[B_XFER] = 1'b1;
        end
        if (clock_second_tick_in) begin
            n.sub_a[B_SEC] = 1'b1;
        end
        if (clock_minute_tick_in) begin
            n.sub_a[B_MIN] = 1'b1;
        end
        if (temperature_event_in) begin
            n.sub_a[B_TEMP] = 1'b1;
        end
        // Core lines 2 to 6
        if (s.pol[B_X2_POL] ? (line2 & ~s.int2_p) : (~line2 & s.int2_p)) begin
            n.xreq[B_X2] = 1'b1;
        end
        if (s.pol[B_X3_POL] ? (ce_busy_in & ~s.busy_p) : (~ce_busy_in & s.busy_p)) begin
            n.xreq[B_X3] = 1'b1;
        end
        if (supply_status_field_in != s.vst_p) begin
            n.xreq[B_X4] = 1'b1;
        end
        if (line5 & ~s.int5_p) begin
            n.xreq[B_X5] = 1'b1;
        end
        if (line6 & ~s.int6_p) begin
            n.xreq[B_X6] = 1'b1;
        end

        // Sample flags once per machine cycle
        pend = {s.xreq[B_X6], s.xreq[B_X5], serial_zero_request_in, s.xreq[B_X4],
                s.tmr_ctl[B_T1_FLAG], s.xreq[B_X3], s.tmr_ctl[B_X1_FLAG], s.xreq[B_X2],
                s.tmr_ctl[B_T0_FLAG], serial_one_request_in, s.tmr_ctl[B_X0_FLAG]};
        if (machine_cycle_in) begin
            n.smp = pend;
        end
        if (vect) begin
            n.smp[s.src] = 1'b0;
        end
        ens = {s.en_b[B_X6], s.en_b[B_X5], s.en_a[B_EN_S0], s.en_b[B_X4],
               s.en_a[B_EN_T1], s.en_b[B_X3], s.en_a[B_EN_X1], s.en_b[B_X2],
               s.en_a[B_EN_T0], s.en_c[B_EN_S1], s.en_a[B_EN_X0]};

        // Poll samples; equal level keeps lower index
        found = 1'b0;
        best = 4'h0;
        best_lvl = 2'h0;
        for (int i = 0; i < NSRC; i++) begin
            if (s.smp[i] && ens[i] && (!found || lvl_of(s.prio_lo, s.prio_hi, i) > best_lvl)) begin
                found = 1'b1;
                best = 4'(i);
                best_lvl = lvl_of(s.prio_lo, s.prio_hi, i);
            end
        end
        cur = top_act(s.act);

        // Acknowledge at instruction end
        blk_now = s.blk | reti_in
                | hit(sfr_wr_in, sfr_addr_in, A_EN_FIRST)
                | hit(sfr_wr_in, sfr_addr_in, A_EN_SECOND)
                | hit(sfr_wr_in, sfr_addr_in, A_EN_THIRD)
                | hit(sfr_wr_in, sfr_addr_in, A_PRIO_LOW)
                | hit(sfr_wr_in, sfr_addr_in, A_PRIO_HIGH);
        n.blk = blk_now;
        if (instr_end_in) begin
            n.blk = 1'b0;
            if (found && s.en_a[B_GLOBAL] && !blk_now && !s.req && !vect
                && (!cur[2] || best_lvl > cur[1:0])) begin
                n.req = 1'b1;
                n.src = best;
                n.vec = VEC_TABLE[best];
            end
        end

        // Return from service
        if (reti_in && cur[2]) begin
            n.act[cur[1:0]] = 1'b0;
        end

        // Register reads
        n.rdata = BYTE_ZERO;
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                A_TIMER_CTRL: n.rdata = s.tmr_ctl;
                A_EN_FIRST:   n.rdata = s.en_a;
                A_EN_SECOND:  n.rdata = s.en_b;
                A_EN_THIRD:   n.rdata = s.en_c;
                A_PRIO_LOW:   n.rdata = s.prio_lo;
                A_PRIO_HIGH:  n.rdata = s.prio_hi;
                A_POL_CTRL:   n.rdata = s.pol;
                A_REQ_FLAGS:  n.rdata = s.xreq;
                A_SUB_FLAG_A: n.rdata = s.sub_a & M_SUB_A;
                A_SUB_FLAG_B: n.rdata = s.sub_b & M_SUB_B;
                default:      n.rdata = BYTE_ZERO;
            endcase
        end
        n.sub_a = n.sub_a & M_SUB_A;
        n.sub_b = n.sub_b & M_SUB_B;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s <= '0;
            s.pin_m <= '1;
            s.pin_s <= '1;
            s.pin_p <= '1;
        end else begin
            s <= n;
        end
    end

    assign sfr_rdata_out = s.rdata;
    assign lcall_req_out = s.req;
    assign lcall_vector_out = s.vec;
    assign irq_source_out = s.src;
    assign timer_zero_service_ack_out = s.ack0;
    assign timer_one_service_ack_out = s.ack1;
    assign timer_run_out = {s.tmr_ctl[B_T1_RUN], s.tmr_ctl[B_T0_RUN]};
endmodule
`default_nettype wire

//--- test/mic_props.sv
/*
 Port assertions for the interrupt controller.
 Assumes one clock domain and binding onto mic_top.
*/
`timescale 1ns/10ps
`default_nettype none
module mic_props
    import mic_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic [7:0]  sfr_addr_in,
    input wire logic        sfr_wr_in,
    input wire logic        sfr_rd_in,
    input wire logic [7:0]  sfr_rdata_out,
    input wire logic        instr_end_in,
    input wire logic        reti_in,
    input wire logic        lcall_ack_in,
    input wire logic        lcall_req_out,
    input wire logic [15:0] lcall_vector_out,
    input wire logic [3:0]  irq_source_out,
    input wire logic        timer_zero_service_ack_out,
    input wire logic        timer_one_service_ack_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic blk_wr;
    assign blk_wr = sfr_wr_in && (sfr_addr_in inside {A_EN_FIRST, A_EN_SECOND, A_EN_THIRD, A_PRIO_LOW, A_PRIO_HIGH});
    a_rdata_one_cycle: assert property (sfr_rd_in ##1 !sfr_rd_in |=> sfr_rdata_out == BYTE_ZERO)
        else $error("read data stands too long");
    a_req_holds: assert property (lcall_req_out && !lcall_ack_in |=> lcall_req_out)
        else $error("call request dropped before ack");
    a_req_release: assert property (lcall_req_out && lcall_ack_in |=> !lcall_req_out)
        else $error("call request held after ack");
    a_grant_at_end: assert property ($rose(lcall_req_out) |-> $past(instr_end_in))
        else $error("call granted off instruction end");
    a_block_grant: assert property (instr_end_in && (reti_in || blk_wr) && !lcall_req_out |=> !lcall_req_out)
        else $error("call granted in blocked instruction");
    a_vector_fixed: assert property (lcall_req_out |-> lcall_vector_out == VEC_TABLE[irq_source_out])
        else $error("vector does not match source");
    a_t0_ack_pulse: assert property (lcall_ack_in && lcall_req_out && irq_source_out == S_T0
        |=> timer_zero_service_ack_out ##1 !timer_zero_service_ack_out)
        else $error("timer 0 ack pulse wrong");
    a_t1_ack_pulse: assert property (lcall_ack_in && lcall_req_out && irq_source_out == S_T1
        |=> timer_one_service_ack_out ##1 !timer_one_service_ack_out)
        else $error("timer 1 ack pulse wrong");
    c_t0_ack: cover property (timer_zero_service_ack_out);
    c_t1_ack: cover property (timer_one_service_ack_out);
    c_x4_call: cover property (lcall_req_out && irq_source_out == S_X4);
endmodule
bind mic_top mic_props u_props (.clk_in, .rst_b_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out,
    .instr_end_in, .reti_in, .lcall_ack_in, .lcall_req_out, .lcall_vector_out, .irq_source_out,
    .timer_zero_service_ack_out, .timer_one_service_ack_out);
`default_nettype wire

//--- test/mic_core_model.sv
/*
 Processor core model: machine cycle and instruction end pulses, call ack.
 Assumes the controller samples on the rising edge; drives on falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module mic_core_model (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // Call handshake
    input  wire logic lcall_req_in,
    input  wire logic slow_in,
    output var logic  machine_cycle_out,
    output var logic  instr_end_out,
    output var logic  lcall_ack_out
);
    logic [1:0] phase = 2'h0;
    logic [1:0] delay = 2'h0;
    initial begin
        machine_cycle_out = 1'b0;
        instr_end_out = 1'b0;
        lcall_ack_out = 1'b0;
    end
    always @(negedge clk_in) begin
        lcall_ack_out = 1'b0;
        if (!rst_b_in) begin
            phase = 2'h0;
            delay = 2'h0;
        end else begin
            phase = phase + 2'h1;
            if (lcall_req_in && delay == (slow_in ? 2'h3 : 2'h0)) begin
                lcall_ack_out = 1'b1;
                delay = 2'h0;
            end else if (lcall_req_in) begin
                delay = delay + 2'h1;
            end
        end
        machine_cycle_out = rst_b_in && phase[0];
        instr_end_out = rst_b_in && phase == 2'h3;
    end
endmodule
`default_nettype wire

//--- test/mic_top_tb_top.sv
/*
 Self-checking bench for the interrupt controller.
 Assumes the core model on the call handshake; inputs change on falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module mic_top_tb_top;
    import mic_pkg::*;
    logic clk_in = 1'b0, rst_b_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, reti_in = 1'b0, slow = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out, sub_enable_a_in = 8'h00;
    logic [7:0] sub_enable_b_in = 8'h00;
    logic timer_zero_overflow_in = 1'b0, timer_one_overflow_in = 1'b0, serial_zero_request_in = 1'b0;
    logic serial_one_request_in = 1'b0, ext_zero_pin_in = 1'b1, ext_one_pin_in = 1'b1, x_pulse_in = 1'b0;
    logic y_pulse_in = 1'b0, w_pulse_in = 1'b0, v_pulse_in = 1'b0, ce_busy_in = 1'b0, eeprom_busy_in = 1'b0;
    logic serial_port_event_in = 1'b0, transfer_busy_signal_in = 1'b0, clock_second_tick_in = 1'b0;
    logic clock_minute_tick_in = 1'b0, temperature_event_in = 1'b0;
    logic [2:0] supply_status_field_in = 3'h0;
    logic machine_cycle_in, instr_end_in, lcall_ack_in, lcall_req_out;
    logic timer_zero_service_ack_out, timer_one_service_ack_out;
    logic [15:0] lcall_vector_out;
    logic [3:0] irq_source_out;
    logic [1:0] timer_run_out;
    int errors = 0, compares = 0, cycles = 0;
    mic_top DUT (.clk_in, .rst_b_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
        .machine_cycle_in, .instr_end_in, .reti_in, .lcall_ack_in, .lcall_req_out, .lcall_vector_out,
        .irq_source_out, .timer_zero_service_ack_out, .timer_one_service_ack_out, .timer_run_out,
        .timer_zero_overflow_in, .timer_one_overflow_in, .serial_zero_request_in, .serial_one_request_in,
        .ext_zero_pin_in, .ext_one_pin_in, .x_pulse_in, .y_pulse_in, .w_pulse_in, .v_pulse_in, .ce_busy_in,
        .supply_status_field_in, .eeprom_busy_in, .serial_port_event_in, .transfer_busy_signal_in,
        .clock_second_tick_in, .clock_minute_tick_in, .temperature_event_in, .sub_enable_a_in, .sub_enable_b_in);
    mic_core_model u_core (.clk_in, .rst_b_in, .lcall_req_in(lcall_req_out), .slow_in(slow),
        .machine_cycle_out(machine_cycle_in), .instr_end_out(instr_end_in), .lcall_ack_out(lcall_ack_in));
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(negedge clk_in);
        sfr_wr_in = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(negedge clk_in);
        sfr_addr_in = a;
        sfr_rd_in = 1'b1;
        @(negedge clk_in);
        sfr_rd_in = 1'b0;
        check(16'(sfr_rdata_out), 16'(exp), msg);
    endtask
    task automatic expect_call(input logic [3:0] src, input string msg);
        int n;
        n = 0;
        while (lcall_req_out !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        check(16'(lcall_req_out), 16'h0001, msg);
        check(lcall_vector_out, VEC_TABLE[src], msg);
        check(16'(irq_source_out), 16'(src), msg);
        while (lcall_req_out === 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        check(16'(lcall_req_out), 16'h0000, msg);
    endtask
    task automatic expect_quiet(input string msg);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(negedge clk_in);
            seen = seen | lcall_req_out;
        end
        check(16'(seen), 16'h0000, msg);
    endtask
    task automatic end_service();
        @(negedge clk_in);
        reti_in = 1'b1;
        @(negedge clk_in);
        reti_in = 1'b0;
    endtask
    task automatic reg_map();
        logic [7:0] a [6] = '{8'hA8, 8'hB8, 8'h9A, 8'hC8, 8'hA9, 8'h90};
        logic [7:0] m [6] = '{8'h9F, 8'h3E, 8'h01, 8'h60, 8'h3F, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rdchk(a[i], 8'h00, "reset value");
            wr(a[i], 8'hFF);
            rdchk(a[i], m[i], "implemented bits");
            wr(a[i], 8'h00);
        end
    endtask
    task automatic timer_zero_flow();
        wr(A_EN_FIRST, 8'h02);
        @(negedge clk_in);
        timer_zero_overflow_in = 1'b1;
        @(negedge clk_in);
        timer_zero_overflow_in = 1'b0;
        expect_quiet("global enable off");
        rdchk(A_TIMER_CTRL, 8'h20, "flag set while off");
        wr(A_EN_FIRST, 8'h82);
        expect_call(S_T0, "timer 0 call");
        rdchk(A_TIMER_CTRL, 8'h00, "timer 0 flag cleared");
    endtask
    task automatic preempt_flow();
        slow = 1'b1;
        wr(A_EN_FIRST, 8'h8A);
        @(negedge clk_in);
        timer_one_overflow_in = 1'b1;
        @(negedge clk_in);
        timer_one_overflow_in = 1'b0;
        expect_quiet("equal level waits");
        wr(A_PRIO_LOW, 8'h08);
        expect_call(S_T1, "higher level preempts");
        rdchk(A_TIMER_CTRL, 8'h00, "timer 1 flag cleared");
        end_service();
        end_service();
        slow = 1'b0;
    endtask
    task automatic status_and_pin_flow();
        wr(A_PRIO_LOW, 8'h00);
        wr(A_EN_FIRST, 8'h80);
        wr(A_EN_SECOND, 8'h0A);
        @(negedge clk_in);
        supply_status_field_in = 3'h5;
        expect_call(S_X4, "status change call");
        rdchk(A_REQ_FLAGS, 8'h00, "ext 4 flag cleared");
        end_service();
        wr(A_TIMER_CTRL, 8'h01);
        wr(A_EN_FIRST, 8'h81);
        @(negedge clk_in);
        ext_zero_pin_in = 1'b0;
        expect_call(S_X0, "falling edge call");
        rdchk(A_TIMER_CTRL, 8'h01, "ext 0 flag cleared");
        end_service();
    endtask
    task automatic sub_flag_flow();
        sub_enable_a_in = 8'h40;
        x_pulse_in = 1'b1;
        @(negedge clk_in);
        x_pulse_in = 1'b0;
        wr(A_SUB_FLAG_A, 8'hFF);
        rdchk(A_SUB_FLAG_A, 8'h40, "ones ignored");
        wr(A_SUB_FLAG_A, 8'hBF);
        expect_call(S_X2, "ext 2 line fall");
    endtask
    initial begin
        repeat (2) @(negedge clk_in);
        rst_b_in = 1'b1;
        reg_map();
        timer_zero_flow();
        preempt_flow();
        status_and_pin_flow();
        sub_flag_flow();
        complete_run();
    end
endmodule
`default_nettype wire
